// ===== src/scs_cfg.svh
// constants for the system clock switch controller
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// register byte addresses
`define SCS_ADDR_CTRL     12'h000
`define SCS_ADDR_IRQ_STAT 12'h004
`define SCS_ADDR_IRQ_MASK 12'h008
`define SCS_ADDR_OSC_CFG  12'h00C

// control register field positions
`define SCS_CUR_HI        14
`define SCS_CUR_LO        12
`define SCS_NXT_HI        10
`define SCS_NXT_LO        8
`define SCS_LOCK_BIT      5
`define SCS_CFAIL_BIT     3
`define SCS_SEC_EN_BIT    1
`define SCS_REQ_BIT       0

// unlock keys
`define SCS_KEY_HI_A      8'h78
`define SCS_KEY_HI_B      8'h9A
`define SCS_KEY_LO_A      8'h46
`define SCS_KEY_LO_B      8'h57

// timing
`define SCS_SETTLE_CYCLES 10
`define SCS_OST_CYCLES    1024
`define SCS_PLL_TIMEOUT   4096

// interrupt status bits
`define SCS_IRQ_DONE      0
`define SCS_IRQ_ABORT     1
`define SCS_IRQ_FAIL      2
`define SCS_IRQ_W         3

`endif

// ===== src/scs_pkg.sv
// types for the system clock switch controller
package scs_pkg;

    // source codes of the next/current source fields
    typedef enum logic [2:0] {
        SRC_FAST_RC      = 3'h0,
        SRC_FAST_RC_MULT = 3'h1,
        SRC_PRIMARY      = 3'h2,
        SRC_PRIMARY_MULT = 3'h3,
        SRC_SECONDARY    = 3'h4,
        SRC_LOW_POWER_RC = 3'h5,
        SRC_RSVD6        = 3'h6,
        SRC_FAST_RC_DIV  = 3'h7
    } scs_src_t;

    typedef enum logic [1:0] {
        SUB_EXTERNAL = 2'h0,
        SUB_CRYSTAL  = 2'h1,
        SUB_HS       = 2'h2,
        SUB_OFF      = 2'h3
    } scs_sub_t;

    typedef enum {
        ST_IDLE,
        ST_COMPARE,
        ST_START,
        ST_WAIT_READY,
        ST_SETTLE,
        ST_SWAP
    } scs_state_t;

endpackage : scs_pkg

// ===== src/scs_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module scs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,     // clock
    input  wire logic             rst_n,   // async reset
    input  wire logic [WIDTH-1:0] din,     // async input
    output logic      [WIDTH-1:0] dout     // filtered output
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // change accepted only when stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    dout[i] <= 1'b0;
                end else if (s2_ff[i] == s3_ff[i]) begin
                    dout[i] <= s3_ff[i];
                end
            end
        end
    endgenerate
endmodule : scs_sync

// ===== src/scs_timer.sv
// down counter used for start-up waits and multiplier lock timeouts
`timescale 1ns/1ns
module scs_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,     // clock
    input  wire logic             rst_n,   // async reset
    input  wire logic             load,    // load pulse
    input  wire logic [WIDTH-1:0] count,   // cycles to count
    output logic                  expired  // level, high when count done
);
    logic [WIDTH-1:0] cnt_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= count;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= !load && (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1} || cnt_ff == '0);
        end
    end
endmodule : scs_timer

// ===== src/scs_ctrl.sv
// system clock switch controller with apb register access
//
// Operation
// - software picks one of eight clock source codes
// - primary submode fixed by configuration only
// - switching enabled only when config bit zero
// - disabled: next select ignored, current shows initial
// - disabled: request bit ignores writes, reads zero
// - equal sources: clear request, abort switch
// - valid switch clears lock and fail flags
// - start oscillator, wait startup timer or lock
// - count ten new-clock cycles before changeover
// - changeover clears request, copies next to current
// - stop old source unless still needed
// - processor keeps running during switch
//
// Our own choices: the placing of the registers and register access over APB.
`include "scs_cfg.svh"
`timescale 1ns/1ns
module scs_ctrl #(
    parameter int OST_CYCLES  = `SCS_OST_CYCLES,
    parameter int PLL_TIMEOUT = `SCS_PLL_TIMEOUT,
    parameter int TW          = 16
) (
    input  wire logic        pclk,            // apb clock
    input  wire logic        presetn,         // async reset, low active
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    input  wire logic [3:0]  pstrb,           // apb byte strobes
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error
    input  wire logic        switch_monitor_config_bit, // 0 enables switching
    input  wire logic [2:0]  initial_source_config,     // source after reset
    input  wire logic [1:0]  primary_submode_config,    // primary submode
    input  wire logic        watchdog_uses_low_power_rc_oscillator,        // low_power_rc_oscillator needed elsewhere
    input  wire logic [7:0]  osc_ready_in,    // async per-source running flags
    input  wire logic        pll_lock_in,     // async multiplier lock
    input  wire logic        new_clk_tick_in, // async toggle of new source
    input  wire logic        clock_fail_in,   // async monitor fail event
    output logic      [7:0]  osc_enable,      // per-source oscillator enable
    output logic      [2:0]  sys_clk_sel,     // active system source
    output logic      [1:0]  primary_submode, // latched primary submode
    output logic             switch_busy,     // switch sequence active
    output logic             irq              // level interrupt
);
    initial begin
        if (OST_CYCLES < 1 || OST_CYCLES >= (1 << TW) || PLL_TIMEOUT < 1
            || PLL_TIMEOUT >= (1 << TW))
            $error("scs_ctrl: timer parameters out of range");
    end

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [7:0] osc_ready;
    logic       pll_lock;
    logic       tick_lvl;
    logic       cfail_lvl;

    scs_sync #(.WIDTH(11)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .din   ({osc_ready_in, pll_lock_in, new_clk_tick_in, clock_fail_in}),
        .dout  ({osc_ready, pll_lock, tick_lvl, cfail_lvl})
    );

    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    scs_pkg::scs_state_t state_ff;
    logic [2:0]  cur_ff;
    logic [2:0]  nxt_src_ff;
    logic        req_ff;
    logic        lock_ff;
    logic        cfail_ff;
    logic        sec_en_ff;
    logic [1:0]  unl_hi_ff;
    logic [1:0]  unl_lo_ff;
    logic [`SCS_IRQ_W-1:0] ist_ff;
    logic [`SCS_IRQ_W-1:0] imask_ff;
    logic        en_ff;
    logic        started_ff;
    logic        tick_d_ff;
    logic [3:0]  settle_ff;
    logic        tmr_load;
    logic [TW-1:0] tmr_count;
    logic        tmr_exp;

    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire wr_ctl = wr_acc && paddr == `SCS_ADDR_CTRL;
    wire hi_wr  = wr_ctl && pstrb[1];
    wire lo_wr  = wr_ctl && pstrb[0];
    wire [7:0] hi_b = pwdata[15:8];
    wire [7:0] lo_b = pwdata[7:0];
    wire hi_open = unl_hi_ff == 2'd2;
    wire lo_open = unl_lo_ff == 2'd2;
    wire tick_edge = tick_lvl ^ tick_d_ff;

    function automatic logic is_crystal(input logic [2:0] s, input logic [1:0] sub);
        is_crystal = (s == scs_pkg::SRC_PRIMARY || s == scs_pkg::SRC_PRIMARY_MULT
                      || s == scs_pkg::SRC_SECONDARY) && sub != scs_pkg::SUB_EXTERNAL;
    endfunction : is_crystal

    function automatic logic uses_mult(input logic [2:0] s);
        uses_mult = s == scs_pkg::SRC_PRIMARY_MULT || s == scs_pkg::SRC_FAST_RC_MULT;
    endfunction : uses_mult

    // enable and submode caught after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started_ff      <= 1'b0;
            en_ff           <= 1'b0;
            primary_submode <= 2'h0;
        end else if (!started_ff) begin
            started_ff      <= 1'b1;
            en_ff           <= !switch_monitor_config_bit;
            primary_submode <= primary_submode_config;
        end
    end

    // ----------------------------------------------------------------
    // unlock sequencers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_hi_ff <= 2'd0;
        end else if (wr_acc) begin
            // any other write cancels the sequence
            if (hi_wr && unl_hi_ff == 2'd0 && hi_b == `SCS_KEY_HI_A)
                unl_hi_ff <= 2'd1;
            else if (hi_wr && unl_hi_ff == 2'd1 && hi_b == `SCS_KEY_HI_B)
                unl_hi_ff <= 2'd2;
            else if (hi_wr && hi_b == `SCS_KEY_HI_A)
                unl_hi_ff <= 2'd1;
            else
                unl_hi_ff <= 2'd0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_lo_ff <= 2'd0;
        end else if (wr_acc) begin
            if (lo_wr && unl_lo_ff == 2'd0 && lo_b == `SCS_KEY_LO_A)
                unl_lo_ff <= 2'd1;
            else if (lo_wr && unl_lo_ff == 2'd1 && lo_b == `SCS_KEY_LO_B)
                unl_lo_ff <= 2'd2;
            else if (lo_wr && lo_b == `SCS_KEY_LO_A)
                unl_lo_ff <= 2'd1;
            else
                unl_lo_ff <= 2'd0;
        end
    end

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nxt_src_ff <= 3'h0;
            sec_en_ff  <= 1'b0;
        end else if (!started_ff) begin
            nxt_src_ff <= initial_source_config;
        end else begin
            if (hi_wr && hi_open && en_ff)
                nxt_src_ff <= hi_b[`SCS_NXT_HI-8:`SCS_NXT_LO-8];
            if (lo_wr && lo_open)
                sec_en_ff <= lo_b[`SCS_SEC_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff <= 1'b0;
        end else if (!en_ff) begin
            req_ff <= 1'b0;
        end else if (state_ff == scs_pkg::ST_COMPARE && nxt_src_ff == cur_ff) begin
            req_ff <= 1'b0;
        end else if (state_ff == scs_pkg::ST_SWAP) begin
            req_ff <= 1'b0;
        end else if (lo_wr && lo_open && lo_b[`SCS_REQ_BIT] && state_ff == scs_pkg::ST_IDLE) begin
            req_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // switch sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= scs_pkg::ST_IDLE;
        end else begin
            unique case (state_ff)
                scs_pkg::ST_IDLE:
                    if (req_ff && en_ff) state_ff <= scs_pkg::ST_COMPARE;
                scs_pkg::ST_COMPARE:
                    state_ff <= (nxt_src_ff == cur_ff) ? scs_pkg::ST_IDLE
                                                       : scs_pkg::ST_START;
                scs_pkg::ST_START:
                    state_ff <= scs_pkg::ST_WAIT_READY;
                scs_pkg::ST_WAIT_READY:
                    if (uses_mult(nxt_src_ff) ? (pll_lock && lock_ff)
                        : (tmr_exp && osc_ready[nxt_src_ff]))
                        state_ff <= scs_pkg::ST_SETTLE;
                    else if (uses_mult(nxt_src_ff) && tmr_exp)
                        state_ff <= scs_pkg::ST_IDLE;   // lock never came, request stays set
                scs_pkg::ST_SETTLE:
                    if (settle_ff == 4'(`SCS_SETTLE_CYCLES)) state_ff <= scs_pkg::ST_SWAP;
                scs_pkg::ST_SWAP:
                    state_ff <= scs_pkg::ST_IDLE;
            endcase
        end
    end

    // timer: startup wait for crystals, lock timeout for multiplier
    always_comb begin
        tmr_load  = state_ff == scs_pkg::ST_START;
        tmr_count = uses_mult(nxt_src_ff) ? TW'(PLL_TIMEOUT)
                  : (is_crystal(nxt_src_ff, primary_submode) && !osc_ready[nxt_src_ff])
                    ? TW'(OST_CYCLES) : TW'(1);
    end

    scs_timer #(.WIDTH(TW)) u_timer (
        .clk     (pclk),
        .rst_n   (presetn),
        .load    (tmr_load),
        .count   (tmr_count),
        .expired (tmr_exp)
    );

    // new-clock cycle counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_d_ff <= 1'b0;
            settle_ff <= 4'h0;
        end else begin
            tick_d_ff <= tick_lvl;
            if (state_ff != scs_pkg::ST_SETTLE)
                settle_ff <= 4'h0;
            else if (tick_edge && settle_ff != 4'(`SCS_SETTLE_CYCLES))
                settle_ff <= settle_ff + 4'h1;
        end
    end

    // status flags; a fail event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff  <= 1'b0;
            cfail_ff <= 1'b0;
        end else begin
            if (state_ff == scs_pkg::ST_START)
                lock_ff <= 1'b0;
            else
                lock_ff <= pll_lock;
            if (cfail_lvl && en_ff)
                cfail_ff <= 1'b1;
            else if (state_ff == scs_pkg::ST_START)
                cfail_ff <= 1'b0;
        end
    end

    // current source and oscillator enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff     <= 3'h0;
            osc_enable <= 8'h00;
        end else if (!started_ff) begin
            cur_ff     <= initial_source_config;
            osc_enable <= 8'h01 << initial_source_config;
        end else begin
            if (state_ff == scs_pkg::ST_START)
                osc_enable[nxt_src_ff] <= 1'b1;
            if (state_ff == scs_pkg::ST_SWAP) begin
                cur_ff <= nxt_src_ff;
                if (!((cur_ff == scs_pkg::SRC_LOW_POWER_RC && watchdog_uses_low_power_rc_oscillator)
                      || (cur_ff == scs_pkg::SRC_SECONDARY && sec_en_ff)))
                    osc_enable[cur_ff] <= 1'b0;
            end
            if (sec_en_ff)
                osc_enable[scs_pkg::SRC_SECONDARY] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // outputs and interrupts
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_sel <= 3'h0;
            switch_busy <= 1'b0;
        end else begin
            sys_clk_sel <= (state_ff == scs_pkg::ST_SWAP) ? nxt_src_ff : cur_ff;
            switch_busy <= state_ff != scs_pkg::ST_IDLE;
        end
    end

    logic [`SCS_IRQ_W-1:0] ev;
    always_comb begin
        ev = '0;
        ev[`SCS_IRQ_DONE]  = state_ff == scs_pkg::ST_SWAP;
        ev[`SCS_IRQ_ABORT] = state_ff == scs_pkg::ST_COMPARE && nxt_src_ff == cur_ff;
        ev[`SCS_IRQ_FAIL]  = state_ff == scs_pkg::ST_WAIT_READY && uses_mult(nxt_src_ff)
                             && tmr_exp && !(pll_lock && lock_ff);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_ff   <= '0;
            imask_ff <= '0;
            irq      <= 1'b0;
        end else begin
            if (wr_acc && paddr == `SCS_ADDR_IRQ_STAT && pstrb[0])
                ist_ff <= (ist_ff & ~pwdata[`SCS_IRQ_W-1:0]) | ev;
            else
                ist_ff <= ist_ff | ev;
            if (wr_acc && paddr == `SCS_ADDR_IRQ_MASK && pstrb[0])
                imask_ff <= pwdata[`SCS_IRQ_W-1:0];
            irq <= |(ist_ff & imask_ff);
        end
    end

    // ----------------------------------------------------------------
    // apb read path, zero wait states
    // ----------------------------------------------------------------
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0;
        unique case (paddr)
            `SCS_ADDR_CTRL: begin
                rd[`SCS_CUR_HI:`SCS_CUR_LO] = cur_ff;
                rd[`SCS_NXT_HI:`SCS_NXT_LO] = nxt_src_ff;
                rd[`SCS_LOCK_BIT]           = lock_ff;
                rd[`SCS_CFAIL_BIT]          = cfail_ff;
                rd[`SCS_SEC_EN_BIT]         = sec_en_ff;
                rd[`SCS_REQ_BIT]            = req_ff && en_ff;
            end
            `SCS_ADDR_IRQ_STAT: rd[`SCS_IRQ_W-1:0] = ist_ff;
            `SCS_ADDR_IRQ_MASK: rd[`SCS_IRQ_W-1:0] = imask_ff;
            `SCS_ADDR_OSC_CFG:  rd[5:0] = {primary_submode, en_ff, 3'h0};
            default:            rd = 32'h0;
        endcase
    end

    wire mapped = paddr == `SCS_ADDR_CTRL || paddr == `SCS_ADDR_IRQ_STAT
               || paddr == `SCS_ADDR_IRQ_MASK || paddr == `SCS_ADDR_OSC_CFG;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd : 32'h0;
        end
    end
endmodule : scs_ctrl

// ===== test/scs_ctrl_sva.sv
// assertion checker for the clock switch controller ports
`timescale 1ns/1ns
module scs_ctrl_chk #(
    parameter int OST_CYCLES  = 1024,
    parameter int PLL_TIMEOUT = 4096
) (
    input wire logic        pclk,                      // clock
    input wire logic        presetn,                   // async reset
    input wire logic        psel,                      // apb select
    input wire logic        penable,                   // apb enable
    input wire logic        pready,                    // apb ready
    input wire logic        pslverr,                   // apb error
    input wire logic [31:0] prdata,                    // apb read data
    input wire logic        switch_monitor_config_bit, // 0 enables switching
    input wire logic        switch_busy,               // sequence active
    input wire logic [2:0]  sys_clk_sel,               // active source
    input wire logic [7:0]  osc_enable,                // oscillator enables
    input wire logic [1:0]  primary_submode            // latched submode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // settles once straps and the initial source are loaded
    logic [2:0] up_ff;
    wire        alive = (up_ff >= 3'h4);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_ff <= 3'h0;
        else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
    end
    property p_rdy_setup; psel && !penable |=> pready; endproperty
    a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
    property p_err_rdy; pslverr |-> pready && psel && penable && prdata == 32'h0; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("error outside access");
    property p_submode; alive |-> $stable(primary_submode); endproperty
    a_submode: assert property (p_submode) else $error("submode changed");
    property p_disabled; alive && switch_monitor_config_bit |-> !switch_busy; endproperty
    a_disabled: assert property (p_disabled) else $error("switch while off");
    property p_cur_on; alive |-> osc_enable[sys_clk_sel]; endproperty
    a_cur_on: assert property (p_cur_on) else $error("current source off");
    property p_bound; $rose(switch_busy) |-> ##[1:1000] !switch_busy; endproperty
    a_bound: assert property (p_bound) else $error("switch never ends");
    property p_settle; $rose(switch_busy) |=> $stable(sys_clk_sel) [*8]; endproperty
    a_settle: assert property (p_settle) else $error("early changeover");
    property p_swap; alive && $changed(sys_clk_sel) |-> $past(switch_busy); endproperty
    a_swap: assert property (p_swap) else $error("source changed idle");
endmodule : scs_ctrl_chk

bind scs_ctrl scs_ctrl_chk #(.OST_CYCLES(OST_CYCLES), .PLL_TIMEOUT(PLL_TIMEOUT)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .switch_monitor_config_bit(switch_monitor_config_bit),
    .switch_busy(switch_busy), .sys_clk_sel(sys_clk_sel), .osc_enable(osc_enable),
    .primary_submode(primary_submode));

// ===== test/tb.sv
// self-checking bench for the clock switch controller
`timescale 1ns/1ns
`include "scs_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, err, switch_busy, irq;
    logic        cfg_bit = 1'b0, pll_lock = 1'b1, tick = 1'b0;
    logic [2:0]  init_src = 3'h0, sys_clk_sel;
    logic [1:0]  tcnt = 2'h0, primary_submode;
    logic [7:0]  osc_enable;
    int          n_fail = 0, n_checks = 0;
    always #5 pclk = ~pclk;
    // new source runs at a quarter of the bus clock
    always @(posedge pclk) begin
        tcnt <= tcnt + 2'h1;
        if (&tcnt) tick <= ~tick;
    end
    scs_ctrl #(.OST_CYCLES(4), .PLL_TIMEOUT(16)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .switch_monitor_config_bit(cfg_bit),
        .initial_source_config(init_src), .primary_submode_config(2'h1),
        .watchdog_uses_low_power_rc_oscillator(1'b0), .osc_ready_in(osc_enable), .pll_lock_in(pll_lock),
        .new_clk_tick_in(tick), .clock_fail_in(1'b0), .osc_enable(osc_enable),
        .sys_clk_sel(sys_clk_sel), .primary_submode(primary_submode),
        .switch_busy(switch_busy), .irq(irq));
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task do_reset(input logic cfg, input logic [2:0] src);
        presetn <= 1'b0;
        cfg_bit <= cfg;
        init_src <= src;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : do_reset
    task switch_to(input logic [2:0] src);
        int k;
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_7800, 4'h2);
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_9A00, 4'h2);
        apb(1'b1, `SCS_ADDR_CTRL, {21'h0, src, 8'h00}, 4'h2);
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_0046, 4'h1);
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_0057, 4'h1);
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_0001, 4'h1);
        k = 0;
        repeat (3) @(posedge pclk);
        while (switch_busy !== 1'b0 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        `CHK(switch_busy, 1'b0)
        apb(1'b0, `SCS_ADDR_CTRL, 32'h0, 4'h0);
    endtask : switch_to
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end
    initial begin
        do_reset(1'b0, 3'h0);
        `CHK(sys_clk_sel, 3'h0)
        `CHK(primary_submode, 2'h1)
        apb(1'b0, `SCS_ADDR_OSC_CFG, 32'h0, 4'h0);
        `CHK(rdata[5:3], 3'h3)
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        `CHK({err, rdata}, 33'h1_0000_0000)
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_7800, 4'h2);
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_9A00, 4'h2);
        apb(1'b1, `SCS_ADDR_IRQ_MASK, 32'h0000_0007, 4'hF);
        apb(1'b1, `SCS_ADDR_CTRL, 32'h0000_0400, 4'h2);
        apb(1'b0, `SCS_ADDR_CTRL, 32'h0, 4'h0);
        `CHK(rdata[10:8], 3'h0)
        $display("test protect done");
        switch_to(3'h1);
        `CHK({rdata[14:12], rdata[5], rdata[0]}, 5'h06)
        `CHK(sys_clk_sel, 3'h1)
        switch_to(3'h4);
        `CHK({rdata[14:12], rdata[10:8], rdata[0]}, 7'h48)
        `CHK(osc_enable, 8'h10)
        `CHK(irq, 1'b1)
        apb(1'b1, `SCS_ADDR_IRQ_STAT, 32'h0000_0007, 4'hF);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        $display("test switch done");
        switch_to(3'h4);
        `CHK({rdata[14:12], rdata[0]}, 4'h8)
        apb(1'b0, `SCS_ADDR_IRQ_STAT, 32'h0, 4'h0);
        `CHK(rdata[2:0], 3'h2)
        apb(1'b1, `SCS_ADDR_IRQ_MASK, 32'h0000_0000, 4'hF);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, `SCS_ADDR_IRQ_STAT, 32'h0000_0007, 4'hF);
        $display("test abort done");
        pll_lock <= 1'b0;
        switch_to(3'h3);
        `CHK({rdata[5], rdata[0]}, 2'h1)
        `CHK(sys_clk_sel, 3'h4)
        $display("test lock fail done");
        pll_lock <= 1'b1;
        do_reset(1'b1, 3'h5);
        `CHK(sys_clk_sel, 3'h5)
        switch_to(3'h2);
        `CHK({rdata[14:12], rdata[0]}, 4'hA)
        apb(1'b0, `SCS_ADDR_OSC_CFG, 32'h0, 4'h0);
        `CHK(rdata[3], 1'b0)
        $display("test disabled done");
        final_report();
    end
endmodule : tb
